// *** char_lcd_command_decoder.sv ***
// command decoder of a two-line character display controller
// assumes panel bus inputs synchronous to clk_in, AHB-Lite single master
//
// The implementer's own choices: the address map and the AHB-Lite register port.
`timescale 1ns/10ps
`include "char_lcd_defines.svh"

module char_lcd_command_decoder #(
   parameter int EXEC_CYC =
      (`EXEC_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
   parameter int CLEAR_CYC =
      (`CLEAR_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
   parameter int BLINK_CYC = `BLINK_TIME_NS / `CLK_PERIOD_NS
) (
   input wire logic clk_in, // core clock
   input wire logic sys_rst_in, // sync reset, high
   input wire logic panel_strobe_in, // panel strobe
   input wire logic reg_sel_line_in, // 0 command, 1 data
   input wire logic rw_in, // 1 read, 0 write
   input wire logic [3:0] nibble_in, // data nibble from host
   output logic [3:0] nibble_out, // read nibble to host
   output logic nibble_oe_out, // high while driving
   output char_lcd_pkg::entry_opts_s opts_out, // option bits
   output logic [6:0] cursor_addr_out, // address counter
   output logic [5:0] shift_offset_out, // display shift
   output logic cursor_underline_out, // underline visible
   output logic cursor_blink_out, // blink block lit
   output logic busy_out, // controller busy flag
   input wire logic hsel_in, // ahb select
   input wire logic [31:0] haddr_in, // ahb address
   input wire logic [1:0] htrans_in, // ahb transfer type
   input wire logic hwrite_in, // ahb write
   input wire logic [2:0] hsize_in, // ahb size
   input wire logic [31:0] hwdata_in, // ahb write data
   input wire logic hready_in, // ahb ready
   output logic [31:0] hrdata_out, // ahb read data
   output logic hreadyout_out, // ahb slave ready
   output logic hresp_out // ahb response
);

   localparam int BW = $clog2(CLEAR_CYC + 1);
   localparam int KW = $clog2(BLINK_CYC + 1);

   // ***********************************************************
   // declarations
   // ***********************************************************
   char_lcd_pkg::dec_state_e state_r;
   char_lcd_pkg::entry_opts_s opts_r;
   logic [BW-1:0] busy_cnt_r;
   logic [KW-1:0] blink_cnt_r;
   logic blink_ph_r;
   logic [6:0] fill_idx_r;
   logic [6:0] ac_r;
   logic dd_sel_r;
   logic [5:0] offset_r;
   logic strobe_d_r;
   logic phase_r;
   logic [3:0] hi_r;
   logic [7:0] rd_byte_r;
   logic ctrl_en_r;
   logic ahb_wr_r;
   logic [7:0] ahb_addr_r;
   logic [7:0] char_mem [`CHAR_DEPTH];
   logic [7:0] glyph_mem [`GLYPH_DEPTH];
   logic accept;
   logic byte_go;
   logic go;
   logic [7:0] byte_val;
   logic cmd_wr;
   logic data_wr;
   logic data_rd;
   logic stat_rd;
   logic is_busy;
   logic [7:0] mem_rd;

   // step the counter one place, wrapping lines in character memory
   function automatic logic [6:0] ac_step(input logic [6:0] a,
         input logic up, input logic dd);
      logic [6:0] r;
      r = a;
      if (dd && up) begin
         if (a == `DD_LINE1_END) r = `DD_LINE2_START;
         else if (a == `DD_LINE2_END) r = `DD_HOME;
         else r = a + 7'h01;
      end else if (dd) begin
         if (a == `DD_HOME) r = `DD_LINE2_END;
         else if (a == `DD_LINE2_START) r = `DD_LINE1_END;
         else r = a - 7'h01;
      end else if (up) begin
         r = {1'b0, a[5:0] + 6'h01};
      end else begin
         r = {1'b0, a[5:0] - 6'h01};
      end
      return r;
   endfunction : ac_step

   // move the window one place, both lines together
   function automatic logic [5:0] off_step(input logic [5:0] o,
         input logic left);
      logic [5:0] r;
      r = o;
      if (left) r = (o == `SHIFT_MAX) ? 6'h00 : o + 6'h01;
      else r = (o == 6'h00) ? `SHIFT_MAX : o - 6'h01;
      return r;
   endfunction : off_step

   // ***********************************************************
   // panel bus nibble assembly
   // ***********************************************************
   // strobe edge, gated by software enable
   assign accept = panel_strobe_in & ~strobe_d_r & ctrl_en_r;
   assign byte_go = accept & phase_r;
   assign byte_val = {hi_r, nibble_in};
   assign is_busy = (state_r != char_lcd_pkg::ST_IDLE);
   assign stat_rd = byte_go & rw_in & ~reg_sel_line_in;
   // refuse everything but status reads while busy
   assign go = byte_go & ~is_busy;
   assign cmd_wr = go & ~rw_in & ~reg_sel_line_in;
   assign data_wr = go & ~rw_in & reg_sel_line_in;
   assign data_rd = go & rw_in & reg_sel_line_in;
   assign mem_rd = dd_sel_r ? char_mem[ac_r] : glyph_mem[ac_r[5:0]];

   // strobe edge history and nibble phase
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         strobe_d_r <= 1'b0;
         phase_r <= 1'b0;
         hi_r <= 4'h0;
      end else begin
         strobe_d_r <= panel_strobe_in;
         if (accept) begin
            phase_r <= ~phase_r;
            if (!phase_r) hi_r <= nibble_in;
         end
      end
   end

   a_nibble_phase: assert property (@(posedge clk_in)
      disable iff (sys_rst_in) accept |=> phase_r != $past(phase_r))
      else $error("nibble phase did not toggle");
   a_strobe_idle: assert property (@(posedge clk_in)
      disable iff (sys_rst_in)
      !panel_strobe_in ##1 !panel_strobe_in |-> $stable(phase_r))
      else $error("bus acted with strobe low");

   // read byte captured at first nibble, shown while strobe high
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         rd_byte_r <= 8'h00;
         nibble_out <= 4'h0;
         nibble_oe_out <= 1'b0;
      end else begin
         if (accept && !phase_r && rw_in) begin
            if (!reg_sel_line_in) rd_byte_r <= {is_busy, ac_r};
            else rd_byte_r <= is_busy ? 8'h00 : mem_rd;
         end
         nibble_out <= phase_r ? rd_byte_r[7:4] : rd_byte_r[3:0];
         nibble_oe_out <= panel_strobe_in & rw_in & ctrl_en_r;
      end
   end

   a_status_byte: assert property (@(posedge clk_in)
      disable iff (sys_rst_in)
      (accept && !phase_r && rw_in && !reg_sel_line_in)
      |=> rd_byte_r == {$past(is_busy), $past(ac_r)})
      else $error("status byte mismatch");

   // ***********************************************************
   // execution sequencing and busy flag
   // ***********************************************************
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         state_r <= char_lcd_pkg::ST_IDLE;
         busy_cnt_r <= '0;
         fill_idx_r <= 7'h00;
      end else begin
         case (state_r)
            char_lcd_pkg::ST_IDLE: begin
               if (cmd_wr && byte_val == 8'h01) begin
                  state_r <= char_lcd_pkg::ST_CLEAR;
                  busy_cnt_r <= BW'(CLEAR_CYC - 1);
                  fill_idx_r <= 7'h00;
               end else if (cmd_wr || data_wr || data_rd) begin
                  state_r <= char_lcd_pkg::ST_EXEC;
                  busy_cnt_r <= BW'(EXEC_CYC - 1);
               end
            end
            char_lcd_pkg::ST_CLEAR: begin
               busy_cnt_r <= busy_cnt_r - BW'(1);
               fill_idx_r <= fill_idx_r + 7'h01;
               if (fill_idx_r == `FILL_LAST) state_r <= char_lcd_pkg::ST_EXEC;
            end
            char_lcd_pkg::ST_EXEC: begin
               if (busy_cnt_r == '0) state_r <= char_lcd_pkg::ST_IDLE;
               else busy_cnt_r <= busy_cnt_r - BW'(1);
            end
            default: state_r <= char_lcd_pkg::ST_IDLE;
         endcase
      end
   end

   assign busy_out = is_busy;

   a_clear_busy: assert property (@(posedge clk_in)
      disable iff (sys_rst_in)
      (cmd_wr && byte_val == 8'h01)
      |=> state_r == char_lcd_pkg::ST_CLEAR ##128
      state_r == char_lcd_pkg::ST_EXEC)
      else $error("clear fill did not run its length");
   a_busy_refuse: assert property (@(posedge clk_in)
      disable iff (sys_rst_in)
      (byte_go && is_busy && state_r != char_lcd_pkg::ST_CLEAR)
      |=> $stable(opts_r) && $stable(offset_r) && $stable(dd_sel_r))
      else $error("command taken while busy");

   // ***********************************************************
   // memories
   // ***********************************************************
   // clear fill has the port, else host writes
   always_ff @(posedge clk_in) begin
      if (state_r == char_lcd_pkg::ST_CLEAR) begin
         char_mem[fill_idx_r] <= `BLANK_CODE;
      end else if (data_wr && dd_sel_r) begin
         char_mem[ac_r] <= byte_val;
      end
   end

   // glyph bitmaps only change on host writes
   always_ff @(posedge clk_in) begin
      if (data_wr && !dd_sel_r) glyph_mem[ac_r[5:0]] <= byte_val;
   end

   // ***********************************************************
   // address counter, memory select and display shift
   // ***********************************************************
   // command priority follows the highest set bit, lower bits free
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         ac_r <= `DD_HOME;
         dd_sel_r <= 1'b1;
         offset_r <= 6'h00;
      end else if (cmd_wr) begin
         if (byte_val[`CMD_DD_BIT]) begin
            ac_r <= byte_val[6:0];
            dd_sel_r <= 1'b1;
         end else if (byte_val[`CMD_CG_BIT]) begin
            ac_r <= {1'b0, byte_val[5:0]};
            dd_sel_r <= 1'b0;
         end else if (byte_val[`CMD_FN_BIT]) begin
            ac_r <= ac_r;
         end else if (byte_val[`CMD_SHIFT_BIT]) begin
            if (byte_val[`F_SC_BIT])
               offset_r <= off_step(offset_r, ~byte_val[`F_RL_BIT]);
            else
               ac_r <= ac_step(ac_r, byte_val[`F_RL_BIT], dd_sel_r);
         end else if (byte_val[`CMD_DISP_BIT] || byte_val[`CMD_ENTRY_BIT]) begin
            ac_r <= ac_r;
         end else if (byte_val[`CMD_HOME_BIT]) begin
            ac_r <= `DD_HOME;
            offset_r <= 6'h00;
         end else if (byte_val[`CMD_CLEAR_BIT]) begin
            ac_r <= `DD_HOME;
            dd_sel_r <= 1'b1;
            offset_r <= 6'h00;
         end
      end else if (data_wr) begin
         ac_r <= ac_step(ac_r, opts_r.inc, dd_sel_r);
         if (opts_r.shift_en && dd_sel_r)
            offset_r <= off_step(offset_r, opts_r.inc);
      end else if (data_rd) begin
         ac_r <= ac_step(ac_r, opts_r.inc, dd_sel_r);
      end
   end

   a_home_pos: assert property (@(posedge clk_in)
      disable iff (sys_rst_in)
      (cmd_wr && byte_val[7:1] == 7'h01)
      |=> ac_r == `DD_HOME && offset_r == 6'h00)
      else $error("home did not reset position");
   a_write_step: assert property (@(posedge clk_in)
      disable iff (sys_rst_in)
      (data_wr && dd_sel_r && opts_r.inc && ac_r < `DD_LINE1_END)
      |=> ac_r == $past(ac_r) + 7'h01)
      else $error("counter did not step up");
   a_line_wrap: assert property (@(posedge clk_in)
      disable iff (sys_rst_in)
      (cmd_wr && byte_val[7:2] == 6'h05 && dd_sel_r
      && ac_r == `DD_LINE1_END) |=> ac_r == `DD_LINE2_START)
      else $error("cursor did not wrap to line two");
   a_read_noshift: assert property (@(posedge clk_in)
      disable iff (sys_rst_in) data_rd |=> $stable(offset_r))
      else $error("display shifted on a read");

   // ***********************************************************
   // option bits
   // ***********************************************************
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         opts_r <= '{inc: 1'b1, shift_en: 1'b0, disp: 1'b0,
            cursor: 1'b0, blink: 1'b0};
      end else if (cmd_wr && byte_val[7:4] == 4'h0) begin
         if (byte_val[`CMD_DISP_BIT]) begin
            opts_r.disp <= byte_val[`F_DISP_BIT];
            opts_r.cursor <= byte_val[`F_CURS_BIT];
            opts_r.blink <= byte_val[`F_BLINK_BIT];
         end else if (byte_val[`CMD_ENTRY_BIT]) begin
            opts_r.inc <= byte_val[`F_INC_BIT];
            opts_r.shift_en <= byte_val[`F_SHIFT_BIT];
         end else if (byte_val[3:0] == 4'h1) begin
            opts_r <= '{inc: 1'b1, shift_en: 1'b0, disp: 1'b0,
               cursor: 1'b0, blink: 1'b0};
         end
      end
   end

   a_clear_opts: assert property (@(posedge clk_in)
      disable iff (sys_rst_in)
      (cmd_wr && byte_val == 8'h01)
      |=> opts_r.inc && !opts_r.shift_en && !opts_r.disp
      && ac_r == `DD_HOME)
      else $error("clear left options set");

   // ***********************************************************
   // cursor blink and display outputs
   // ***********************************************************
   // half second phase, held at start while blink is off
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         blink_cnt_r <= '0;
         blink_ph_r <= 1'b0;
      end else if (!opts_r.blink) begin
         blink_cnt_r <= '0;
         blink_ph_r <= 1'b0;
      end else if (blink_cnt_r == KW'(BLINK_CYC - 1)) begin
         blink_cnt_r <= '0;
         blink_ph_r <= ~blink_ph_r;
      end else begin
         blink_cnt_r <= blink_cnt_r + KW'(1);
      end
   end

   // registered view of display state
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         cursor_underline_out <= 1'b0;
         cursor_blink_out <= 1'b0;
      end else begin
         cursor_underline_out <= opts_r.disp & opts_r.cursor;
         cursor_blink_out <= opts_r.disp & opts_r.blink & blink_ph_r;
      end
   end

   assign opts_out = opts_r;
   assign cursor_addr_out = ac_r;
   assign shift_offset_out = offset_r;

   // ***********************************************************
   // ahb-lite register slave, zero wait
   // ***********************************************************
   assign hreadyout_out = 1'b1;
   assign hresp_out = 1'b0;

   // address phase capture and read data
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         ahb_wr_r <= 1'b0;
         ahb_addr_r <= 8'h00;
         hrdata_out <= 32'h0000_0000;
      end else if (hready_in) begin
         ahb_wr_r <= hsel_in & htrans_in[1] & hwrite_in;
         ahb_addr_r <= haddr_in[7:0];
         hrdata_out <= 32'h0000_0000;
         if (hsel_in && htrans_in[1] && !hwrite_in) begin
            case (haddr_in[7:0])
               `REG_CTRL: hrdata_out <= {31'h0, ctrl_en_r};
               `REG_STATUS: hrdata_out <= {17'h0, phase_r, opts_r,
                  dd_sel_r, is_busy, ac_r};
               `REG_SHIFT: hrdata_out <= {26'h0, offset_r};
               default: hrdata_out <= 32'h0000_0000;
            endcase
         end
      end
   end

   // control register write in data phase
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) ctrl_en_r <= `CTRL_RST;
      else if (ahb_wr_r && ahb_addr_r == `REG_CTRL)
         ctrl_en_r <= hwdata_in[`CTRL_EN_BIT];
   end

endmodule : char_lcd_command_decoder

// *** char_lcd_command_decoder_tb_top.sv ***
// self-checking bench for the display command decoder
// assumes the host model file and the design files are compiled first
`timescale 1ns/10ps
module char_lcd_command_decoder_tb_top;
   // ***********************************************************
   // signals, design and host
   // ***********************************************************
   typedef struct packed {
      logic rs;
      logic [7:0] b;
      logic [6:0] ac;
      logic [4:0] op;
      logic [5:0] sh;
   } row_s;
   logic clk_in, sys_rst_in, strobe, rs, rw, busy, hready, hresp, host_to;
   logic ul, bl;
   logic [3:0] nib_to, nib_from;
   char_lcd_pkg::entry_opts_s opts;
   logic [6:0] ac;
   logic [5:0] sh;
   logic hsel, hwrite;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata;
   int miscompares = 0;
   int n_compared = 0;
   // rows: select, byte, counter, options, shift after the byte
   row_s rows [0:21] = '{
      {1'b0, 8'h01, 7'h00, 5'h10, 6'h00}, // clear
      {1'b0, 8'h0f, 7'h00, 5'h17, 6'h00}, // display, cursor, blink
      {1'b0, 8'h85, 7'h05, 5'h17, 6'h00},
      {1'b1, 8'h41, 7'h06, 5'h17, 6'h00},
      {1'b0, 8'h04, 7'h06, 5'h07, 6'h00}, // decrement
      {1'b1, 8'h42, 7'h05, 5'h07, 6'h00},
      {1'b0, 8'h10, 7'h04, 5'h07, 6'h00}, // cursor left
      {1'b0, 8'h14, 7'h05, 5'h07, 6'h00}, // cursor right
      {1'b0, 8'h18, 7'h05, 5'h07, 6'h01}, // display left
      {1'b0, 8'h1c, 7'h05, 5'h07, 6'h00}, // display right
      {1'b0, 8'h18, 7'h05, 5'h07, 6'h01},
      {1'b0, 8'h03, 7'h00, 5'h07, 6'h00}, // home, low bit set
      {1'b0, 8'h06, 7'h00, 5'h17, 6'h00},
      {1'b0, 8'ha7, 7'h27, 5'h17, 6'h00},
      {1'b0, 8'h14, 7'h40, 5'h17, 6'h00}, // end of line one
      {1'b0, 8'h28, 7'h40, 5'h17, 6'h00}, // function set
      {1'b0, 8'h07, 7'h40, 5'h1f, 6'h00},
      {1'b1, 8'h43, 7'h41, 5'h1f, 6'h01}, // write with shift
      {1'b0, 8'h0b, 7'h41, 5'h1b, 6'h01}, // display off
      {1'b0, 8'h06, 7'h41, 5'h13, 6'h01},
      {1'b0, 8'h42, 7'h02, 5'h13, 6'h01}, // glyph address
      {1'b1, 8'h15, 7'h03, 5'h13, 6'h01}
   };

   char_lcd_command_decoder #(.EXEC_CYC(20), .CLEAR_CYC(200),
      .BLINK_CYC(16)) i_char_lcd_command_decoder (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in), .panel_strobe_in(strobe),
      .reg_sel_line_in(rs), .rw_in(rw), .nibble_in(nib_to),
      .nibble_out(nib_from), .nibble_oe_out(), .opts_out(opts),
      .cursor_addr_out(ac), .shift_offset_out(sh),
      .cursor_underline_out(ul), .cursor_blink_out(bl), .busy_out(busy),
      .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
      .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
      .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
      .hresp_out(hresp));

   char_lcd_host_model i_char_lcd_host_model (.clk_in(clk_in),
      .busy_in(busy), .rd_nibble_in(nib_from), .strobe_out(strobe),
      .rs_out(rs), .rw_out(rw), .nibble_out(nib_to), .timeout_out(host_to));

   // ***********************************************************
   // clock and tasks
   // ***********************************************************
   // 200 MHz core clock
   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end

   // verdict and end of run
   task automatic finish_test();
      if (host_to !== 1'b0) miscompares++;
      $display("compared %0d, miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : finish_test

   // a host busy wait that ran out ends the run
   always @(posedge host_to) finish_test();

   // one comparison
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // bounded wait for hready at a rising edge
   task automatic wait_rdy();
      int i;
      for (i = 0; i < 50; i++) begin
         @(posedge clk_in);
         if (hready === 1'b1) break;
      end
      if (i == 50) begin
         miscompares++;
         finish_test();
      end
   endtask : wait_rdy

   // single word transfer on the register bus
   task automatic ahb(input logic wr, input logic [31:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clk_in);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= wr;
      wait_rdy();
      htrans <= 2'b00;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
   endtask : ahb

   // ***********************************************************
   // main sequence
   // ***********************************************************
   initial begin
      logic [7:0] q;
      logic [31:0] d;
      int k;
      sys_rst_in = 1'b1;
      hsel = 1'b0;
      htrans = 2'b00;
      haddr = 32'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      repeat (2) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      @(posedge clk_in);
      chk("opts", 32'h10, opts);
      chk("busy", 32'h0, busy);
      ahb(1'b0, 32'h0, 32'h0, d);
      chk("ctrl", 32'h1, d);
      ahb(1'b0, 32'hc, 32'h0, d);
      chk("unmapped", 32'h0, d);
      chk("hresp", 32'h0, hresp);
      $display("test reset done");
      // command table
      for (k = 0; k < 22; k++) begin
         i_char_lcd_host_model.xfer(rows[k].rs, 1'b0, rows[k].b, 1'b1, q);
         chk("ac", rows[k].ac, ac);
         chk("opts", rows[k].op, opts);
         chk("shift", rows[k].sh, sh);
      end
      $display("test table done");
      // read back with shift on: counter steps, display stays
      i_char_lcd_host_model.xfer(1'b0, 1'b0, 8'h07, 1'b1, q);
      i_char_lcd_host_model.xfer(1'b0, 1'b0, 8'hc0, 1'b1, q);
      i_char_lcd_host_model.xfer(1'b1, 1'b1, 8'h00, 1'b1, q);
      chk("rd_dd", 32'h43, q);
      chk("rd_ac", 32'h41, ac);
      chk("rd_shift", 32'h01, sh);
      i_char_lcd_host_model.xfer(1'b0, 1'b0, 8'h42, 1'b1, q);
      i_char_lcd_host_model.xfer(1'b1, 1'b1, 8'h00, 1'b1, q);
      chk("rd_cg", 32'h15, q);
      ahb(1'b0, 32'h4, 32'h0, d);
      chk("sel", 32'h0, d[8]);
      $display("test readback done");
      // status during clear, then blanks and forced increment
      i_char_lcd_host_model.xfer(1'b0, 1'b0, 8'h01, 1'b0, q);
      i_char_lcd_host_model.xfer(1'b0, 1'b1, 8'h00, 1'b0, q);
      chk("bf", 32'h1, q[7]);
      i_char_lcd_host_model.xfer(1'b0, 1'b0, 8'h80, 1'b1, q);
      i_char_lcd_host_model.xfer(1'b1, 1'b1, 8'h00, 1'b1, q);
      chk("blank", 32'h20, q);
      i_char_lcd_host_model.xfer(1'b0, 1'b1, 8'h00, 1'b1, q);
      chk("status", 32'h01, q);
      $display("test clear done");
      // panel disabled: strobes ignored, phase kept
      ahb(1'b1, 32'h0, 32'h0, d);
      i_char_lcd_host_model.xfer(1'b0, 1'b0, 8'h85, 1'b0, q);
      chk("dis_ac", 32'h01, ac);
      ahb(1'b0, 32'h4, 32'h0, d);
      chk("dis_phase", 32'h0, d[14]);
      ahb(1'b1, 32'h0, 32'h1, d);
      i_char_lcd_host_model.xfer(1'b0, 1'b0, 8'h85, 1'b1, q);
      chk("en_ac", 32'h05, ac);
      // display with cursor and blink: underline lit, blink phase toggles
      i_char_lcd_host_model.xfer(1'b0, 1'b0, 8'h0f, 1'b1, q);
      chk("underline", 32'h1, ul);
      for (k = 0; k < 64 && bl !== 1'b1; k++) @(posedge clk_in);
      chk("blink", 32'h1, bl);
      $display("test disable done");
      finish_test();
   end
endmodule : char_lcd_command_decoder_tb_top

// *** char_lcd_defines.svh ***
// constants for the character display command decoder
// assumes a 200 MHz core clock and a 32-bit AHB-Lite register bus
`ifndef CHAR_LCD_DEFINES_SVH
`define CHAR_LCD_DEFINES_SVH

// ***********************************************************
// timing
// ***********************************************************
`define CLK_PERIOD_NS 5
`define EXEC_TIME_NS 40000
`define CLEAR_TIME_NS 1640000
`define BLINK_TIME_NS 500000000

// ***********************************************************
// command decode bit positions
// ***********************************************************
`define CMD_DD_BIT 7
`define CMD_CG_BIT 6
`define CMD_FN_BIT 5
`define CMD_SHIFT_BIT 4
`define CMD_DISP_BIT 3
`define CMD_ENTRY_BIT 2
`define CMD_HOME_BIT 1
`define CMD_CLEAR_BIT 0
`define F_INC_BIT 1
`define F_SHIFT_BIT 0
`define F_DISP_BIT 2
`define F_CURS_BIT 1
`define F_BLINK_BIT 0
`define F_SC_BIT 3
`define F_RL_BIT 2

// ***********************************************************
// memory layout
// ***********************************************************
`define BLANK_CODE 8'h20
`define DD_HOME 7'h00
`define DD_LINE1_END 7'h27
`define DD_LINE2_START 7'h40
`define DD_LINE2_END 7'h67
`define SHIFT_MAX 6'h27
`define CHAR_DEPTH 128
`define GLYPH_DEPTH 64
`define FILL_LAST 7'h7f

// ***********************************************************
// register map
// ***********************************************************
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_SHIFT 8'h08
`define CTRL_RST 1'b1
`define CTRL_EN_BIT 0

`endif

// *** char_lcd_host_model.sv ***
// host model that drives the panel bus of the display command decoder
// assumes the decoder samples the bus on rising edges of clk_in
`timescale 1ns/10ps
module char_lcd_host_model #(
   parameter int GAP = 200 // cycles between halves, one microsecond
) (
   input wire logic clk_in, // core clock
   input wire logic busy_in, // decoder busy flag
   input wire logic [3:0] rd_nibble_in, // nibble read back
   output logic strobe_out, // panel strobe
   output logic rs_out, // register select
   output logic rw_out, // 1 read, 0 write
   output logic [3:0] nibble_out, // nibble to decoder
   output logic timeout_out // busy wait ran out
);
   // ***********************************************************
   // idle bus and transfers
   // ***********************************************************
   // bus idle at time zero
   initial begin
      strobe_out = 1'b0;
      rs_out = 1'b0;
      rw_out = 1'b0;
      nibble_out = 4'h0;
      timeout_out = 1'b0;
   end

   // one half transfer; lines scrambled while strobe is low
   task automatic half(input logic rs, input logic rw,
                       input logic [3:0] n, output logic [3:0] q);
      @(posedge clk_in);
      rs_out <= rs;
      rw_out <= rw;
      nibble_out <= rw ? ~nibble_out : n; // inverted on reads
      @(posedge clk_in);
      strobe_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      q = rd_nibble_in;
      strobe_out <= 1'b0;
      rs_out <= ~rs;
      rw_out <= ~rw;
      nibble_out <= ~nibble_out;
   endtask : half

   // whole byte, high half first, optional wait for busy low
   task automatic xfer(input logic rs, input logic rw, input logic [7:0] b,
                       input logic wt, output logic [7:0] q);
      int i;
      half(rs, rw, b[7:4], q[7:4]);
      repeat (GAP) @(posedge clk_in);
      half(rs, rw, b[3:0], q[3:0]);
      if (wt) begin
         repeat (3) @(posedge clk_in);
         // no next byte until busy drops
         for (i = 0; i < 1000 && busy_in !== 1'b0; i++) @(posedge clk_in);
         if (i == 1000) timeout_out <= 1'b1;
      end
   endtask : xfer
endmodule : char_lcd_host_model

// *** char_lcd_pkg.sv ***
// types shared by the character display command decoder
// assumes char_lcd_defines.svh supplies all numbers except the state encodings
package char_lcd_pkg;

   // entry and display option bits
   typedef struct packed {
      logic inc;
      logic shift_en;
      logic disp;
      logic cursor;
      logic blink;
   } entry_opts_s;

   // decoder execution states, one-hot
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_CLEAR = 3'b010,
      ST_EXEC = 3'b100
   } dec_state_e;

endpackage : char_lcd_pkg
